// File: inc/acq_trig_regs.vh
// Overview of operation
// RL1 - Sources: channel level, external, software, window, re-arm, OR/AND, delayed trigger.
// RL2 - One engine per channel with two levels, plus two external trigger inputs.
// RL3 - Each source fires on rising, falling or both edges; in AND mode the code uses the rising edge of the combined level.
// RL4 - Trigger delay 0 to 8589934576 samples, in steps of 16.
// RL5 - Multi, gated, dual-rate: 40 samples plus pretrigger before next trigger.
// RL6 - Pretrigger from 16 to 8192 samples in steps of 16.
// RL7 - Posttrigger and memory depth 32 to memory per channel, steps of 16.
// RL8 - Segment size 32 to half memory per channel, steps of 16.
// RL9 - Averaging factor only 2, 4, 8, 16, 32, 64, 128 or 256.
// RL10 - Timestamp modes: free-running, cleared at start, reference pulse.
// RL11 - Standard modes: 64 bit counter per sample, cleared by command or start.
// RL12 - Reference mode: upper 24 bits count reference pulses.
// RL13 - Reference mode: lower 40 bits count samples, cleared per pulse.
// RL14 - Stamp extra data: none, multipurpose inputs, or OR trigger source.
// RL15 - External trigger pulses last at least 2 sample periods.
// RL16 - External thresholds span plus or minus 10 V in 10 mV steps.
// RL17 - Sample clock from internal PLL or external reference clock.
// RL18 - Standard clock: maximum rate divided by power of two, 1 to 131072.
// RL19 - Special clock: 1 Hz steps, only on an unsynchronised single card.
// RL20 - Special clock refuses the five forbidden frequency bands.
// RL21 - External reference clock lies between 10 MHz and 1 GHz.
// RL22 - Configuration writes during acquisition are ignored until stopped.
`ifndef ACQ_TRIG_REGS_VH
`define ACQ_TRIG_REGS_VH
// Register indices
`define R_CTRL    5'h00
`define R_MODE    5'h01
`define R_SRC_EN  5'h02
`define R_EDGE    5'h03
`define R_DELAY   5'h04
`define R_PRE     5'h05
`define R_POST    5'h06
`define R_MEM     5'h07
`define R_SEG     5'h08
`define R_AVG     5'h09
`define R_NCHAN   5'h0a
`define R_CLK     5'h0b
`define R_RATE    5'h0c
`define R_XLVL0   5'h0d
`define R_XLVL1   5'h0e
`define R_XLVL2   5'h0f
`define R_STAMP_L 5'h10
`define R_STAMP_H 5'h11
`define R_STAMP_X 5'h12
`define R_CHLVL   5'h14
// Control bits
`define C_START   0
`define C_STOP    1
`define C_SWTRIG  2
`define C_TSCLR   3
`define C_ERRCLR  4
// Mode fields
`define M_ACQ     2:0
`define M_TS      4:3
`define M_EXTRA   6:5
`define M_AND     7
`define ACQ_SINGLE 3'h0
`define ACQ_MULTI  3'h1
`define ACQ_GATE   3'h2
`define ACQ_DUAL   3'h3
`define ACQ_FIFO   3'h4
`define ACQ_AVG    3'h5
`define TS_FREE   2'h0
`define TS_START  2'h1
`define TS_REF    2'h2
`define X_NONE    2'h0
`define X_MPIN    2'h1
`define X_SRC     2'h2
// Clock fields
`define K_EXT     0
`define K_DIV     5:1
`define K_SPECIAL 6
`define K_SYNC    7
`define DIV_MAX   5'h11
// Sizes, lengths in units of 16 samples except REARM_SAMP, which is in samples
`define STEP_LOG2   4
`define REARM_SAMP  34'h28
`define PRE_MIN     10'h001
`define PRE_MAX     10'h200
`define LEN_MIN     28'h0000002
`define DELAY_MAX   29'h1fffffff
`define LVL_MAX     11'h3e8
`define AVG_MIN     9'h002
`define AVG_MAX     9'h100
// Reset values
`define RST_MODE    8'h00
`define RST_PRE     10'h001
`define RST_LEN     28'h0000002
`define RST_AVG     9'h002
`define RST_NCHAN   3'h1
`define RST_RATE    32'h0
`endif

// File: hdl/acq_trigger_timestamp_clock.v
`timescale 1ns/100ps
`include "acq_trig_regs.vh"
module acq_trigger_timestamp_clock #(
  parameter NCH       = 4,
  parameter MEM_UNITS = 28'h8000000
)(
  input  wire                 clk_i,
  input  wire                 reset_i,
  input  wire [4:0]           addr_i,
  input  wire [31:0]          wdata_i,
  input  wire                 wr_i,
  input  wire                 rd_i,
  output reg  [31:0]          rdata_o,
  input  wire [2*NCH-1:0]     chan_hit_i,
  input  wire [1:0]           window_ext_trigger_input_i,
  input  wire                 level_ext_trigger_input_i,
  input  wire [2:0]           multipurpose_inputs_i,
  output reg  [2*NCH*14-1:0]  chan_level_o,
  output reg  [10:0]          ext_level0_o,
  output reg  [10:0]          ext_level1_o,
  output reg  [10:0]          ext_level2_o,
  output reg                  clk_ext_sel_o,
  output reg  [4:0]           clk_div_exp_o,
  output reg                  special_clk_o,
  output reg  [31:0]          rate_o,
  output reg  [8:0]           avg_factor_o,
  output reg                  sample_en_o,
  output reg                  running_o,
  output reg                  trigger_o,
  output reg                  record_o,
  output reg                  segment_end_o,
  output reg                  stamp_valid_o,
  output reg  [63:0]          stamp_o,
  output reg  [15:0]          stamp_extra_o
);
  localparam NSRC = 2*NCH+3;
  localparam WIN  = 2*NCH;
  localparam LEVEL_EXT_TRIGGER_INPUT = 2*NCH+1;
  localparam REARM = 2*NCH+2;
  localparam S_IDLE = 5'h01;
  localparam S_ARM  = 5'h02;
  localparam S_WAIT = 5'h04;
  localparam S_DLY  = 5'h08;
  localparam S_POST = 5'h10;

  // Edge match for one source: 1 rising, 2 falling, 3 both
  function edge_hit;
    input [1:0] cfg;
    input       prev;
    input       cur;
    begin
      edge_hit = (cfg[0] & ~prev & cur) | (cfg[1] & prev & ~cur);
    end
  endfunction

  // Forbidden special clock bands in Hz
  function rate_bad;
    input [31:0] r;
    begin
      rate_bad = (r >= 32'd17500000 && r <= 32'd17900000) ||
                 (r >= 32'd35100000 && r <= 32'd35800000) ||
                 (r >= 32'd70000000 && r <= 32'd72000000) ||
                 (r >= 32'd140000000 && r <= 32'd144000000) ||
                 (r >= 32'd281000000 && r <= 32'd287000000);
    end
  endfunction

  // Length limit in 16-sample units for given channel count
  function [27:0] len_lim;
    input [2:0] nch;
    input       half;
    reg   [27:0] m;
    begin
      m = half ? {1'b0, MEM_UNITS[27:1]} : MEM_UNITS[27:0];
      len_lim = nch[2] ? {2'b00, m[27:2]} :
                nch[1] ? {1'b0, m[27:1]} : m;
    end
  endfunction

  reg [7:0]       mode;
  reg [NSRC-1:0]  src_en;
  reg [2*NSRC-1:0] edge_cfg;
  reg [28:0]      delay;
  reg [9:0]       pre;
  reg [27:0]      post;
  reg [27:0]      mem_len;
  reg [27:0]      seg;
  reg [2:0]       nchan;
  reg             clk_sync;
  reg             cfg_err;
  reg [4:0]       state;
  reg [33:0]      cnt;
  reg [16:0]      div_cnt;
  reg [NSRC-1:0]  lvl_prev;
  reg             and_prev;
  reg             rearm_armed;
  reg             ref_prev;
  reg [63:0]      ts;
  reg [NSRC-1:0]  lvl;
  wire [NSRC-1:0] hits;
  reg [3:0]       src_id;
  reg             and_lvl;
  reg             hw_trig;
  reg             next_cfg_err;
  reg             wr_bad;
  integer         i;

  wire wr_ok    = wr_i & ~running_o;                    // see RL22
  wire ctl_wr   = wr_i & (addr_i == `R_CTRL);
  wire cmd_start = ctl_wr & wdata_i[`C_START];
  wire cmd_stop  = ctl_wr & wdata_i[`C_STOP];
  wire cmd_sw    = ctl_wr & wdata_i[`C_SWTRIG];         // see RL1
  wire ref_pulse = multipurpose_inputs_i[0] & ~ref_prev;
  wire [27:0] w28 = wdata_i[27:0];
  wire [8:0]  w9  = wdata_i[8:0];
  wire [10:0] lvl_mag = wdata_i[10] ? (~wdata_i[10:0] + 11'h001) : wdata_i[10:0];
  wire lvl_ok  = lvl_mag <= `LVL_MAX;                   // see RL16
  wire multi_rearm = (mode[`M_ACQ] == `ACQ_MULTI) || (mode[`M_ACQ] == `ACQ_GATE) ||
                     (mode[`M_ACQ] == `ACQ_DUAL);

  // Source levels: channel comparators, window, ext level, re-arm
  always @*
  begin
    lvl = {NSRC{1'b0}};
    lvl[2*NCH-1:0] = chan_hit_i;                        // see RL2
    lvl[WIN]   = window_ext_trigger_input_i[0] & ~window_ext_trigger_input_i[1];
    lvl[LEVEL_EXT_TRIGGER_INPUT]  = level_ext_trigger_input_i;
    lvl[REARM] = rearm_armed & window_ext_trigger_input_i[1];
    and_lvl = (&(lvl | ~src_en)) & (|src_en);
  end

  // Per-source edge detectors on sample enable
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1)
    begin : g_edge
      assign hits[g] = src_en[g] & edge_hit(edge_cfg[2*g+1:2*g], lvl_prev[g], lvl[g]); // see RL3
    end
  endgenerate

  // OR/AND combination and lowest firing source index
  always @*
  begin
    src_id = 4'hf;
    for (i = NSRC-1; i >= 0; i = i - 1)
    begin
      if (hits[i])
      begin
        src_id = i[3:0];
      end
    end
    if (mode[`M_AND])
    begin
      hw_trig = sample_en_o & and_lvl & ~and_prev;      // see RL1
    end
    else
    begin
      hw_trig = sample_en_o & (|hits);                  // see RL1
    end
  end

  // Sample enable divider by power of two
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      div_cnt     <= 17'h0;
      sample_en_o <= 1'b0;
    end
    else if (div_cnt >= ((17'h1 << clk_div_exp_o) - 17'h1)) // see RL18
    begin
      div_cnt     <= 17'h0;
      sample_en_o <= 1'b1;
    end
    else
    begin
      div_cnt     <= div_cnt + 17'h1;
      sample_en_o <= 1'b0;
    end
  end

  // Trigger level history and re-arm arming on lower threshold
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      lvl_prev    <= {NSRC{1'b0}};
      and_prev    <= 1'b0;
      rearm_armed <= 1'b0;
      ref_prev    <= 1'b0;
    end
    else
    begin
      ref_prev <= multipurpose_inputs_i[0];
      if (sample_en_o)
      begin
        lvl_prev <= lvl;
        and_prev <= and_lvl;
        if (~window_ext_trigger_input_i[0])
        begin
          rearm_armed <= 1'b1;                          // see RL1
        end
        else if (hits[REARM])
        begin
          rearm_armed <= 1'b0;
        end
      end
    end
  end

  // Configuration register writes with range checks
  always @*
  begin
    next_cfg_err = 1'b0;
    if (wr_i && running_o && addr_i != `R_CTRL)
    begin
      next_cfg_err = 1'b1;
    end
    if (wr_ok)
    begin
      case (addr_i)
        `R_DELAY: if (wdata_i[31:29] != 3'h0) next_cfg_err = 1'b1;
        `R_PRE:   if (wdata_i[9:0] < `PRE_MIN || wdata_i[9:0] > `PRE_MAX) next_cfg_err = 1'b1;
        `R_POST,
        `R_MEM:   if (w28 < `LEN_MIN || w28 > len_lim(nchan, 1'b0)) next_cfg_err = 1'b1;
        `R_SEG:   if (w28 < `LEN_MIN || w28 > len_lim(nchan, 1'b1)) next_cfg_err = 1'b1;
        `R_AVG:   if (w9 < `AVG_MIN || (w9 & (w9 - 9'h1)) != 9'h0) next_cfg_err = 1'b1;
        `R_NCHAN: if (wdata_i[2:0] != 3'h1 && wdata_i[2:0] != 3'h2 &&
                      wdata_i[2:0] != 3'h4) next_cfg_err = 1'b1;
        `R_CLK:   if (wdata_i[`K_DIV] > `DIV_MAX ||
                      (wdata_i[`K_SPECIAL] & wdata_i[`K_SYNC])) next_cfg_err = 1'b1;
        `R_RATE:  if (rate_bad(wdata_i)) next_cfg_err = 1'b1;
        `R_XLVL0,
        `R_XLVL1,
        `R_XLVL2: if (!lvl_ok) next_cfg_err = 1'b1;
        default:  next_cfg_err = next_cfg_err;
      endcase
    end
    // A refused value never lands, even while the error flag is already up
    wr_bad       = next_cfg_err;
    next_cfg_err = cfg_err | wr_bad;
    if (ctl_wr && wdata_i[`C_ERRCLR])
    begin
      next_cfg_err = 1'b0;
    end
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mode          <= `RST_MODE;
      src_en        <= {NSRC{1'b0}};
      edge_cfg      <= {NSRC{2'h1}};
      delay         <= 29'h0;
      pre           <= `RST_PRE;
      post          <= `RST_LEN;
      mem_len       <= `RST_LEN;
      seg           <= `RST_LEN;
      avg_factor_o  <= `RST_AVG;
      nchan         <= `RST_NCHAN;
      clk_ext_sel_o <= 1'b0;
      clk_div_exp_o <= 5'h0;
      special_clk_o <= 1'b0;
      clk_sync      <= 1'b0;
      rate_o        <= `RST_RATE;
      ext_level0_o  <= 11'h0;
      ext_level1_o  <= 11'h0;
      ext_level2_o  <= 11'h0;
      cfg_err       <= 1'b0;
    end
    else
    begin
      cfg_err <= next_cfg_err;
      if (wr_ok && !wr_bad)
      begin
        case (addr_i)
          `R_MODE:   mode <= wdata_i[7:0];
          `R_SRC_EN: src_en <= wdata_i[NSRC-1:0];
          `R_EDGE:   edge_cfg <= wdata_i[2*NSRC-1:0];
          `R_DELAY:  delay <= wdata_i[28:0];            // see RL4
          `R_PRE:    pre <= wdata_i[9:0];               // see RL6
          `R_POST:   post <= w28;                       // see RL7
          `R_MEM:    mem_len <= w28;                    // see RL7
          `R_SEG:    seg <= w28;                        // see RL8
          `R_AVG:    avg_factor_o <= w9;                // see RL9
          `R_NCHAN:  nchan <= wdata_i[2:0];
          `R_CLK:
          begin
            clk_ext_sel_o <= wdata_i[`K_EXT];           // see RL17
            clk_div_exp_o <= wdata_i[`K_DIV];           // see RL18
            special_clk_o <= wdata_i[`K_SPECIAL];       // see RL19
            clk_sync      <= wdata_i[`K_SYNC];
          end
          `R_RATE:   rate_o <= wdata_i;                 // see RL20
          `R_XLVL0:  ext_level0_o <= wdata_i[10:0];     // see RL16
          `R_XLVL1:  ext_level1_o <= wdata_i[10:0];
          `R_XLVL2:  ext_level2_o <= wdata_i[10:0];
          default:   mode <= mode;
        endcase
      end
    end
  end

  // Channel level registers, two per channel
  generate
    for (g = 0; g < 2*NCH; g = g + 1)
    begin : g_chlvl
      always @(posedge clk_i)
      begin
        if (reset_i)
        begin
          chan_level_o[14*g+13:14*g] <= 14'h0;
        end
        else if (wr_ok && addr_i == `R_CHLVL + g)
        begin
          chan_level_o[14*g+13:14*g] <= wdata_i[13:0]; // see RL2
        end
      end
    end
  endgenerate

  // Acquisition sequencer: wait, delay, posttrigger, re-arm
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state         <= S_IDLE;
      cnt           <= 34'h0;
      running_o     <= 1'b0;
      trigger_o     <= 1'b0;
      record_o      <= 1'b0;
      segment_end_o <= 1'b0;
    end
    else
    begin
      trigger_o     <= 1'b0;
      segment_end_o <= 1'b0;
      if (cmd_stop)
      begin
        state     <= S_IDLE;
        running_o <= 1'b0;
        record_o  <= 1'b0;
      end
      else
      begin
        case (state)
          S_IDLE:
          begin
            if (cmd_start)
            begin
              state     <= S_WAIT;
              running_o <= 1'b1;
            end
          end
          S_ARM:
          begin
            if (sample_en_o)
            begin
              if (cnt <= 34'h1)
              begin
                state <= S_WAIT;
              end
              cnt <= cnt - 34'h1;
            end
          end
          S_WAIT:
          begin
            if (hw_trig || cmd_sw)
            begin
              trigger_o <= 1'b1;
              cnt   <= {1'b0, delay, `STEP_LOG2'h0};
              state <= (delay == 29'h0) ? S_POST : S_DLY; // see RL4
              if (delay == 29'h0)
              begin
                cnt      <= {2'b00, post, `STEP_LOG2'h0};
                record_o <= 1'b1;
              end
            end
          end
          S_DLY:
          begin
            if (sample_en_o)
            begin
              cnt <= cnt - 34'h1;
              if (cnt <= 34'h1)
              begin
                cnt      <= {2'b00, post, `STEP_LOG2'h0};
                record_o <= 1'b1;
                state    <= S_POST;
              end
            end
          end
          S_POST:
          begin
            if (sample_en_o)
            begin
              cnt <= cnt - 34'h1;
              if (cnt <= 34'h1)
              begin
                record_o      <= 1'b0;
                segment_end_o <= 1'b1;
                cnt <= `REARM_SAMP + {20'h0, pre, `STEP_LOG2'h0}; // see RL5
                if (mode[`M_ACQ] == `ACQ_SINGLE)
                begin
                  state     <= S_IDLE;
                  running_o <= 1'b0;
                end
                else
                begin
                  state <= multi_rearm ? S_ARM : S_WAIT; // see RL5
                end
              end
            end
          end
          default:
          begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Timestamp counter and capture at trigger
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ts            <= 64'h0;
      stamp_o       <= 64'h0;
      stamp_extra_o <= 16'h0;
      stamp_valid_o <= 1'b0;
    end
    else
    begin
      stamp_valid_o <= 1'b0;
      if (ctl_wr && wdata_i[`C_TSCLR])
      begin
        ts <= 64'h0;                                    // see RL11
      end
      else if (mode[`M_TS] == `TS_START && cmd_start && !running_o)
      begin
        ts <= 64'h0;                                    // see RL10
      end
      else if (mode[`M_TS] == `TS_REF)
      begin
        if (ref_pulse)
        begin
          ts[63:40] <= ts[63:40] + 24'h1;               // see RL12
          ts[39:0]  <= 40'h0;                           // see RL13
        end
        else if (sample_en_o)
        begin
          ts[39:0] <= ts[39:0] + 40'h1;                 // see RL13
        end
      end
      else if (sample_en_o)
      begin
        ts <= ts + 64'h1;                               // see RL11
      end
      if (state == S_WAIT && (hw_trig || cmd_sw) && !cmd_stop)
      begin
        stamp_o       <= ts;
        stamp_valid_o <= 1'b1;
        case (mode[`M_EXTRA])                           // see RL14
          `X_MPIN: stamp_extra_o <= {13'h0, multipurpose_inputs_i};
          `X_SRC:  stamp_extra_o <= {11'h0, cmd_sw, src_id};
          default: stamp_extra_o <= 16'h0;
        endcase
      end
    end
  end

  // Register read, data valid one cycle after the strobe
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_o <= 32'h0;
    end
    else if (rd_i)
    begin
      case (addr_i)
        `R_CTRL:    rdata_o <= {27'h0, cfg_err, state == S_DLY,
                                state == S_WAIT, record_o, running_o};
        `R_MODE:    rdata_o <= {24'h0, mode};
        `R_SRC_EN:  rdata_o <= {{(32-NSRC){1'b0}}, src_en};
        `R_EDGE:    rdata_o <= {{(32-2*NSRC){1'b0}}, edge_cfg};
        `R_DELAY:   rdata_o <= {3'h0, delay};
        `R_PRE:     rdata_o <= {22'h0, pre};
        `R_POST:    rdata_o <= {4'h0, post};
        `R_MEM:     rdata_o <= {4'h0, mem_len};
        `R_SEG:     rdata_o <= {4'h0, seg};
        `R_AVG:     rdata_o <= {23'h0, avg_factor_o};
        `R_NCHAN:   rdata_o <= {29'h0, nchan};
        `R_CLK:     rdata_o <= {24'h0, clk_sync, special_clk_o,
                                clk_div_exp_o, clk_ext_sel_o};
        `R_RATE:    rdata_o <= rate_o;
        `R_XLVL0:   rdata_o <= {21'h0, ext_level0_o};
        `R_XLVL1:   rdata_o <= {21'h0, ext_level1_o};
        `R_XLVL2:   rdata_o <= {21'h0, ext_level2_o};
        `R_STAMP_L: rdata_o <= stamp_o[31:0];
        `R_STAMP_H: rdata_o <= stamp_o[63:32];
        `R_STAMP_X: rdata_o <= {16'h0, stamp_extra_o};
        default:
        begin
          if (addr_i >= `R_CHLVL && addr_i < `R_CHLVL + 2*NCH)
          begin
            rdata_o <= {18'h0, chan_level_o[14*(addr_i-`R_CHLVL) +: 14]};
          end
          else
          begin
            rdata_o <= 32'h0;
          end
        end
      endcase
    end
    else
    begin
      rdata_o <= 32'h0;
    end
  end

endmodule // acq_trigger_timestamp_clock

// File: test/acq_trig_assertions.sv
`timescale 1ns/100ps
module acq_trig_checker (
  input wire        clk_i,
  input wire        reset_i,
  input wire [8:0]  avg_factor_o,
  input wire [4:0]  clk_div_exp_o,
  input wire [10:0] ext_level0_o,
  input wire [31:0] rate_o,
  input wire        running_o,
  input wire        sample_en_o,
  input wire        trigger_o,
  input wire        record_o,
  input wire        stamp_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Setting ranges that software can never break
  chk_avg_pow2: assert property ($onehot(avg_factor_o) && avg_factor_o >= 9'h002)
    else $error("avg factor not a legal power of two");
  chk_div_exp_range: assert property (clk_div_exp_o <= 5'h11)
    else $error("divider exponent above 17");
  chk_ext_level_span: assert property ($signed(ext_level0_o) <= 1000 &&
    $signed(ext_level0_o) >= -1000) else $error("threshold beyond 10 V");
  // Settings stay frozen while running
  chk_cfg_frozen_run: assert property (running_o && $past(running_o) |->
    $stable(avg_factor_o) && $stable(rate_o)) else $error("setting moved while running");
  // Undivided clock gives a sample every cycle
  chk_sample_full_rate: assert property (!$past(reset_i) && !$past(reset_i, 2) &&
    clk_div_exp_o == 5'h00 && $past(clk_div_exp_o) == 5'h00 |-> sample_en_o)
    else $error("sample enable missing at divide by one");
  // Trigger and record framing
  chk_trig_one_cycle: assert property (trigger_o |=> !trigger_o)
    else $error("trigger pulse longer than one cycle");
  chk_trig_while_run: assert property (trigger_o |-> running_o)
    else $error("trigger while idle");
  chk_record_in_run: assert property ($rose(record_o) |-> running_o)
    else $error("recording started while idle");
  chk_stamp_one_cycle: assert property (stamp_valid_o |=> !stamp_valid_o)
    else $error("stamp valid longer than one cycle");
  cov_trigger: cover property (trigger_o);
  cov_record_end: cover property ($fell(record_o));
  cov_stamp: cover property (stamp_valid_o);
endmodule // acq_trig_checker

bind acq_trigger_timestamp_clock acq_trig_checker u_acq_trig_checker (.clk_i, .reset_i,
  .avg_factor_o, .clk_div_exp_o, .ext_level0_o, .rate_o, .running_o, .sample_en_o,
  .trigger_o, .record_o, .stamp_valid_o);

// File: test/ext_signal_source.sv
`timescale 1ns/100ps
module ext_signal_source #(
  parameter HOLD = 2
)(
  input  wire       clk_i,
  input  wire       fire_i,
  input  wire       pulse_i,
  output wire       level_o,
  output wire [1:0] window_o,
  output wire [2:0] mpin_o
);
  integer cnt_t = 0;
  integer cnt_r = 0;
  // Stretch each request to HOLD clock cycles so it is seen reliably
  always @(posedge clk_i)
  begin
    cnt_t <= fire_i ? HOLD : (cnt_t > 0 ? cnt_t - 1 : 0);
    cnt_r <= pulse_i ? HOLD : (cnt_r > 0 ? cnt_r - 1 : 0);
  end
  // Window input rests below both thresholds
  assign level_o = (cnt_t != 0);
  assign window_o = 2'b00;
  assign mpin_o = {2'b00, cnt_r != 0};
endmodule // ext_signal_source

// File: test/acq_trigger_timestamp_clock_tb.sv
`timescale 1ns/100ps
`include "acq_trig_regs.vh"
module acq_trigger_timestamp_clock_tb;
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [4:0] addr_i = 5'h00;
  reg [31:0] wdata_i = 32'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg fire = 1'b0;
  reg pulse = 1'b0;
  reg [31:0] v;
  reg [31:0] bad [0:4];
  wire [31:0] rdata_o;
  wire [31:0] rate_o;
  wire [8:0] avg_factor_o;
  wire [4:0] clk_div_exp_o;
  wire [10:0] ext_level0_o;
  wire [1:0] window;
  wire [2:0] mpin;
  wire level, trigger_o, record_o, running_o, stamp_valid_o;
  integer g0, g1, l, i, fails = 0, num_checks = 0, trigs = 0, stamps = 0;

  acq_trigger_timestamp_clock #(.NCH(4), .MEM_UNITS(28'h100)) u_acq_trigger_timestamp_clock (
    .clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .chan_hit_i(8'h00),
    .window_ext_trigger_input_i(window), .level_ext_trigger_input_i(level),
    .multipurpose_inputs_i(mpin), .chan_level_o(), .ext_level0_o, .ext_level1_o(),
    .ext_level2_o(), .clk_ext_sel_o(), .clk_div_exp_o, .special_clk_o(), .rate_o,
    .avg_factor_o, .sample_en_o(), .running_o, .trigger_o, .record_o, .segment_end_o(),
    .stamp_valid_o, .stamp_o(), .stamp_extra_o());
  ext_signal_source u_ext_signal_source (.clk_i, .fire_i(fire), .pulse_i(pulse),
    .level_o(level), .window_o(window), .mpin_o(mpin));

  // Clock and event counters
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    trigs <= trigs + (trigger_o === 1'b1);
    stamps <= stamps + (stamp_valid_o === 1'b1);
  end

  task chk(input string what, input [63:0] seen, input [63:0] exp);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  end
  endtask
  task wr(input [4:0] a, input [31:0] d);
  begin
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  end
  endtask
  task rd(input [4:0] a);
  begin
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  end
  endtask
  // Error flag is read back, then cleared
  task err(input exp);
  begin
    rd(`R_CTRL);
    chk("cfg_err", v[4], exp);
    wr(`R_CTRL, 32'h10);
  end
  endtask
  // Start, write a setting while running, trigger, then time the record window
  task acquire(input sw, output integer gap, output integer len);
    integer n;
  begin
    wr(`R_CTRL, 32'h1);
    wr(`R_AVG, 32'h4);
    if (sw)
      wr(`R_CTRL, 32'h4);
    else
    begin
      @(posedge clk_i) fire <= 1'b1;
      @(posedge clk_i) fire <= 1'b0;
    end
    gap = 0;
    while (record_o !== 1'b1 && gap < 2000)
      @(posedge clk_i) #1 gap = gap + 1;
    len = 0;
    while (record_o === 1'b1 && len < 2000)
      @(posedge clk_i) #1 len = len + 1;
    n = 0;
    while (running_o === 1'b1 && n < 100)
      @(posedge clk_i) #1 n = n + 1;
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  // Watchdog
  initial
  begin
    #200000;
    fails = fails + 1;
    report_and_stop;
  end

  // Test sequence
  initial
  begin
    bad[0] = 32'h010b0760;
    bad[1] = 32'h02179560;
    bad[2] = 32'h042c1d80;
    bad[3] = 32'h08583b00;
    bad[4] = 32'h111b45c0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`R_MODE);
    chk("mode_rst", v, 32'h0);
    chk("avg_rst", avg_factor_o, 9'h002);
    for (i = 1; i <= 8; i = i + 1)
    begin
      wr(`R_AVG, 32'h1 << i);
      chk("avg", avg_factor_o, 9'h001 << i);
    end
    wr(`R_AVG, 32'h3);
    err(1'b1);
    wr(`R_AVG, 32'h3);
    wr(`R_AVG, 32'h200);
    chk("avg_bad", avg_factor_o, 9'h100);
    err(1'b1);
    wr(`R_AVG, 32'h2);
    $display("test averaging done");
    wr(`R_PRE, 32'h0);
    err(1'b1);
    wr(`R_PRE, 32'h201);
    err(1'b1);
    wr(`R_PRE, 32'h200);
    err(1'b0);
    rd(`R_PRE);
    chk("pre", v, 32'h200);
    wr(`R_PRE, 32'h1);
    $display("test pretrigger done");
    wr(`R_CLK, 32'h22);
    chk("div", clk_div_exp_o, 5'h11);
    wr(`R_CLK, 32'h24);
    err(1'b1);
    wr(`R_CLK, 32'hc0);
    err(1'b1);
    wr(`R_CLK, 32'h40);
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(`R_RATE, bad[i]);
      err(1'b1);
    end
    wr(`R_RATE, 32'h0459e440);
    chk("rate", rate_o, 32'h0459e440);
    wr(`R_CLK, 32'h0);
    $display("test clock done");
    wr(`R_XLVL0, 32'h3e9);
    err(1'b1);
    wr(`R_XLVL0, 32'hfffffc18);
    err(1'b0);
    chk("level", ext_level0_o, 11'h418);
    $display("test levels done");
    wr(`R_POST, 32'h2);
    acquire(1'b1, g0, l);
    chk("rec_len", l, 32);
    err(1'b1);
    chk("avg_kept", avg_factor_o, 9'h002);
    wr(`R_DELAY, 32'h1);
    acquire(1'b1, g1, l);
    chk("delay", g1 - g0, 16);
    err(1'b1);
    $display("test trigger delay done");
    wr(`R_DELAY, 32'h0);
    wr(`R_MODE, 32'h40);
    wr(`R_SRC_EN, 32'h200);
    acquire(1'b0, g0, l);
    rd(`R_STAMP_X);
    chk("src", v[4:0], 5'h09);
    err(1'b1);
    $display("test external trigger done");
    wr(`R_MODE, 32'h10);
    wr(`R_SRC_EN, 32'h0);
    repeat (3)
    begin
      @(posedge clk_i) pulse <= 1'b1;
      @(posedge clk_i) pulse <= 1'b0;
      repeat (10) @(posedge clk_i);
    end
    acquire(1'b1, g0, l);
    rd(`R_STAMP_H);
    chk("ref_cnt", v, 32'h300);
    rd(`R_STAMP_L);
    chk("smp_cnt", v < 32'h200, 1'b1);
    err(1'b1);
    // Multi mode: after a segment the re-arm time refuses a trigger
    wr(`R_MODE, 32'h01);
    wr(`R_PRE, 32'h200);
    acquire(1'b1, g0, l);
    wr(`R_CTRL, 32'h4);
    rd(`R_CTRL);
    chk("rearm", v[2:0], 3'h1);
    wr(`R_CTRL, 32'h2);
    $display("test re-arm done");
    chk("trigs", trigs, 5);
    chk("stamps", stamps, 5);
    $display("test reference stamp done");
    report_and_stop;
  end
endmodule // acq_trigger_timestamp_clock_tb
